// ===== cps_count.sv
/*
  Loadable down counter with a zero flag.
  Assumes load and step come from logic on the same clock.
*/
`default_nettype none
module cps_count #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  input  wire logic         step,
  output logic              zero
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_value;
    end else if (step && cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign zero = (cnt_r == '0);
endmodule
`default_nettype wire

// ===== cps_pkg.sv
/*
  Shared constants and types of the configuration pin sequencer:
  timing, register map, control field positions, modes and states.
  Assumes a 200 MHz system clock.
*/
`default_nettype none
package cps_pkg;
  // ==========================================================
  // timing
  localparam int CLK_MHZ     = 200;
  localparam int WAIT_MIN_US = 50;
  localparam int WAIT_CYC    = WAIT_MIN_US * CLK_MHZ;
  localparam int CLEAR_CYC   = 512;
  localparam int CONFIG_CLOCK_HALF   = 4;
  localparam int CNT_W       = 16;
  localparam int ADDR_W      = 18;
  localparam int BYTE_W      = 8;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BUSY_TICKS = 4'h8;
  localparam logic [6:0] STAT_FILL = 7'h7f;
  // ==========================================================
  // register map, byte offsets
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_STAT  = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam int CTL_DONE_WAIT = 0;
  localparam int CTL_DONE_PU_OFF = 1;
  localparam int CTL_DONE_CLK  = 2;
  localparam int CTL_RB_CLK    = 3;
  localparam int CTL_BSCAN     = 4;
  localparam int CTL_DLY_LSB   = 8;
  localparam int DLY_W         = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0300;
  // ==========================================================
  // modes and states
  typedef enum logic [2:0] {
    MODE_MSER = 3'b000,
    MODE_SSER = 3'b001,
    MODE_MPAR = 3'b010,
    MODE_PSYN = 3'b011,
    MODE_PASY = 3'b100,
    MODE_EXPR = 3'b101
  } cps_mode_t;
  localparam logic [23:0] MODE_TABLE = 24'h20_58d0;
  typedef enum logic [3:0] {
    ST_PROG  = 4'b0000,
    ST_CLEAR = 4'b0001,
    ST_WAIT  = 4'b0010,
    ST_DELAY = 4'b0011,
    ST_LOAD  = 4'b0100,
    ST_START = 4'b0101,
    ST_DWAIT = 4'b0110,
    ST_USER  = 4'b0111,
    ST_ERR   = 4'b1000
  } cps_state_t;
endpackage
`default_nettype wire

// ===== cps_src_model.sv
/* configuration source: PROM data from address, serial source.
   assumes serial data is taken on rising link clock edges. */
`default_nettype none
module cps_src_model (
  input  wire logic        ser_en,
  input  wire logic [17:0] addr,
  input  wire logic        addr_oe,
  output var  logic        link_clk,
  output var  logic [7:0]  data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] last_r = 8'h00;
  logic [7:0] b;
  logic       bit_r = 1'b0;
  int         idx = 0;
  // ====================================================
  // link clock stands high between frames
  initial begin
    link_clk = 1'b1;
    forever begin
      wait (ser_en === 1'b1);
      #80 link_clk = 1'b0;
      b = 8'(idx / 8) ^ 8'h3c;
      bit_r = b[7 - idx % 8];
      #80 link_clk = 1'b1;
      idx++;
    end
  end
  always @* begin
    if (addr_oe) data = addr[7:0] ^ 8'ha5;
    else if (ser_en) data = {7'h00, bit_r};
    else data = ~last_r;
  end
  always @(negedge addr_oe or negedge ser_en) last_r = data;
endmodule
`default_nettype wire

// ===== cps_sync.sv
/*
  Two-flop synchroniser for a bus of independent level inputs.
  Assumes each bit is a slow level; no word coherence is given.
*/
`default_nettype none
module cps_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= RST;
      q      <= RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== cps_top.sv
/*
  Configuration pin sequencer: clear/wait/load/start-up sequence and the
  configuration pins of a programmable device, with an Avalon-MM slave.
  Assumes all pin inputs are asynchronous to clk; data_error and
  scan_data_in come from logic on clk.
*/
// The Avalon-MM slave port and the register offsets are this design's own decisions.
// Behaviour
// - device drives config clock in master modes and asynchronous peripheral.
// - after configuration the config clock may be chosen as readback clock.
// - done pin is driven low until configuration finishes.
// - optionally a low done pin delays global init and output enabling.
// - done release timing, its clock and pull-up are control options.
// - program low clears memory and restarts configuration.
// - program high: one full clear, then wait state and init released.
// - ready pin tells peripheral host when next byte may be written.
// - async peripheral read while selected shows ready on top data line.
// - ready pin only weakly pulled up until init goes high.
// - address-advance strobe rises before every PROM address change.
// - mode pins sampled before loading starts, choosing the mode.
// - mode pins weakly pulled up during configuration; open means slave.
// - after configuration these special pins become user I/O.
// - test data out three-states after configuration unless scan used.
// - master modes wait at least 50 us after init high before loading.
// - data error during loading pulls init low.
// - selected read strobe: top data line status, other lines high.
`default_nettype none
module cps_top #(
  parameter int          CLEAR_CYC    = cps_pkg::CLEAR_CYC,
  parameter int          WAIT_CYC     = cps_pkg::WAIT_CYC,
  parameter int          CONFIG_CLOCK_HALF    = cps_pkg::CONFIG_CLOCK_HALF,
  parameter int          CONFIG_BYTES = 16,
  parameter logic [23:0] MODE_TABLE   = cps_pkg::MODE_TABLE
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        program_n,
  input  wire logic        init_in,
  output logic             init_out,
  output logic             init_oe,
  input  wire logic        done_in,
  output logic             done_out,
  output logic             done_oe,
  output logic             done_pullup_en,
  input  wire logic [2:0]  config_mode_select,
  output logic             mode_pullup_en,
  input  wire logic        config_clock_in,
  output logic             config_clock_out,
  output logic             config_clock_oe,
  output logic             readback_clock_sel,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  input  wire logic        periph_select_low,
  input  wire logic        periph_select_high,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  output logic             byte_ready_out,
  output logic             byte_ready_oe,
  output logic             byte_ready_pullup,
  output logic      [17:0] prom_address_out,
  output logic             prom_address_oe,
  output logic             address_strobe_out,
  input  wire logic        data_error,
  input  wire logic        scan_data_in,
  output logic             tdo_out,
  output logic             tdo_oe,
  output logic             user_io_enable,
  output logic      [7:0]  config_byte,
  output logic             config_byte_valid
);
  // ==========================================================
  // pin synchronisers
  localparam int SYNC_W = 19;
  logic [SYNC_W-1:0] sync_s;
  logic              prog_n_s, init_s, done_s, config_clock_s;
  logic              sel_low_s, sel_high_s, wstrb_n_s, rstrb_n_s;
  logic [2:0]        mode_s;
  logic [7:0]        data_s;

  cps_sync #(
    .W   (SYNC_W),
    .RST (19'h7_ffff)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({program_n, init_in, done_in, config_mode_select,
             config_clock_in, data_in, periph_select_low,
             periph_select_high, write_strobe_n, read_strobe_n}),
    .q     (sync_s)
  );

  assign {prog_n_s, init_s, done_s, mode_s, config_clock_s, data_s, sel_low_s,
          sel_high_s, wstrb_n_s, rstrb_n_s} = sync_s;

  // ==========================================================
  // state, control and loader declarations
  cps_pkg::cps_state_t state_r;
  cps_pkg::cps_mode_t  mode_r;
  logic [31:0]         ctrl_r;
  logic                clr_zero, wait_zero;
  logic [cps_pkg::DLY_W-1:0] start_cnt_r;
  logic [7:0]          div_r;
  logic                config_clock_int_r, config_clock_d_r, wstrb_d_r;
  logic                int_rise, int_fall, ext_rise, tick;
  logic                dev_clocks, clk_run, selected, config_done;
  logic                periph_mode, take, done_rel_r;
  logic [7:0]          shift_r, in_byte;
  logic [3:0]          bit_cnt_r, busy_cnt_r;
  logic [cps_pkg::CNT_W-1:0] byte_cnt_r;
  logic [cps_pkg::ADDR_W-1:0] addr_r;
  logic                astrobe_r;
  cps_pkg::cps_mode_t  table_mode;

  // mode code lookup through the parameter table
  assign table_mode = cps_pkg::cps_mode_t'(MODE_TABLE[mode_s*3 +: 3]);

  assign config_done = (state_r == cps_pkg::ST_USER);
  assign selected    = !sel_low_s && sel_high_s;
  assign periph_mode = (mode_r == cps_pkg::MODE_PSYN) ||
                       (mode_r == cps_pkg::MODE_PASY);
  // device sources the clock in master and async peripheral
  assign dev_clocks  = (mode_r == cps_pkg::MODE_MSER) ||
                       (mode_r == cps_pkg::MODE_MPAR) ||
                       (mode_r == cps_pkg::MODE_PASY);
  assign clk_run     = (state_r == cps_pkg::ST_LOAD) ||
                       (state_r == cps_pkg::ST_START) ||
                       (state_r == cps_pkg::ST_DWAIT);

  // ==========================================================
  // clear and master wait timers
  cps_count #(
    .W (cps_pkg::CNT_W)
  ) u_clear (
    .clk        (clk),
    .reset      (reset),
    .load       (state_r == cps_pkg::ST_PROG),
    .load_value (cps_pkg::CNT_W'(CLEAR_CYC)),
    .step       (state_r == cps_pkg::ST_CLEAR),
    .zero       (clr_zero)
  );

  cps_count #(
    .W (cps_pkg::CNT_W)
  ) u_wait (
    .clk        (clk),
    .reset      (reset),
    .load       (state_r == cps_pkg::ST_WAIT),
    .load_value (cps_pkg::CNT_W'(WAIT_CYC)),
    .step       (state_r == cps_pkg::ST_DELAY),
    .zero       (wait_zero)
  );

  // ==========================================================
  // config clock: own divider, or edges of the sampled pin
  always_ff @(posedge clk) begin
    if (reset || !clk_run) begin
      div_r      <= '0;
      config_clock_int_r <= 1'b0;
    end else if (div_r == 8'(CONFIG_CLOCK_HALF - 1)) begin
      div_r      <= '0;
      config_clock_int_r <= !config_clock_int_r;
    end else begin
      div_r <= div_r + 8'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      config_clock_d_r  <= 1'b1;
      wstrb_d_r <= 1'b1;
    end else begin
      config_clock_d_r  <= config_clock_s;
      wstrb_d_r <= wstrb_n_s;
    end
  end

  assign int_rise = clk_run && (div_r == 8'(CONFIG_CLOCK_HALF - 1)) && !config_clock_int_r;
  assign int_fall = clk_run && (div_r == 8'(CONFIG_CLOCK_HALF - 1)) && config_clock_int_r;
  // source clock may stay high indefinitely; only edges count
  assign ext_rise = config_clock_s && !config_clock_d_r;
  assign tick     = dev_clocks ? int_rise : ext_rise;

  // ==========================================================
  // main sequence
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= cps_pkg::ST_PROG;
    end else if (!prog_n_s) begin
      state_r <= cps_pkg::ST_PROG;
    end else begin
      case (state_r)
        cps_pkg::ST_PROG:  state_r <= cps_pkg::ST_CLEAR;
        cps_pkg::ST_CLEAR: begin
          if (clr_zero) begin
            state_r <= cps_pkg::ST_WAIT;
          end
        end
        cps_pkg::ST_WAIT: begin
          if (init_s) begin
            if (table_mode == cps_pkg::MODE_MSER ||
                table_mode == cps_pkg::MODE_MPAR) begin
              state_r <= cps_pkg::ST_DELAY;
            end else begin
              state_r <= cps_pkg::ST_LOAD;
            end
          end
        end
        cps_pkg::ST_DELAY: begin
          if (wait_zero) begin
            state_r <= cps_pkg::ST_LOAD;
          end
        end
        cps_pkg::ST_LOAD: begin
          if (data_error) begin
            state_r <= cps_pkg::ST_ERR;
          end else if (byte_cnt_r == cps_pkg::CNT_W'(CONFIG_BYTES)) begin
            state_r <= cps_pkg::ST_START;
          end
        end
        cps_pkg::ST_START: begin
          if (done_rel_r) begin
            state_r <= cps_pkg::ST_DWAIT;
          end
        end
        cps_pkg::ST_DWAIT: begin
          if (!ctrl_r[cps_pkg::CTL_DONE_WAIT] || done_s) begin
            state_r <= cps_pkg::ST_USER;
          end
        end
        cps_pkg::ST_USER:  state_r <= cps_pkg::ST_USER;
        cps_pkg::ST_ERR:   state_r <= cps_pkg::ST_ERR;
        default:           state_r <= cps_pkg::ST_PROG;
      endcase
    end
  end

  // mode captured as loading is about to start
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_r <= cps_pkg::MODE_SSER;
    end else if (state_r == cps_pkg::ST_WAIT && init_s) begin
      mode_r <= table_mode;
    end
  end

  // done release after a programmable count on the chosen clock
  always_ff @(posedge clk) begin
    if (reset || state_r != cps_pkg::ST_START) begin
      start_cnt_r <= ctrl_r[cps_pkg::CTL_DLY_LSB +: cps_pkg::DLY_W];
      done_rel_r  <= config_done || (state_r == cps_pkg::ST_DWAIT);
    end else if (start_cnt_r == '0) begin
      done_rel_r <= 1'b1;
    end else if (ctrl_r[cps_pkg::CTL_DONE_CLK] || tick) begin
      start_cnt_r <= start_cnt_r - cps_pkg::DLY_W'(1);
    end
  end

  // ==========================================================
  // byte loader
  always_comb begin
    in_byte = data_s;
    take    = 1'b0;
    case (mode_r)
      cps_pkg::MODE_MSER, cps_pkg::MODE_SSER: begin
        in_byte = {shift_r[6:0], data_s[0]};
        take    = tick && (bit_cnt_r == cps_pkg::BIT_LAST);
      end
      cps_pkg::MODE_MPAR: take = tick;
      cps_pkg::MODE_PSYN: take = tick && (busy_cnt_r == '0);
      cps_pkg::MODE_PASY: take = selected && !wstrb_n_s && wstrb_d_r &&
                                 (busy_cnt_r == '0);
      cps_pkg::MODE_EXPR: take = tick && sel_high_s;
      default:            take = 1'b0;
    endcase
    if (state_r != cps_pkg::ST_LOAD ||
        byte_cnt_r == cps_pkg::CNT_W'(CONFIG_BYTES)) begin
      take = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state_r == cps_pkg::ST_PROG) begin
      shift_r    <= '0;
      bit_cnt_r  <= '0;
      busy_cnt_r <= '0;
      byte_cnt_r <= '0;
    end else if (state_r == cps_pkg::ST_LOAD) begin
      if (tick) begin
        shift_r   <= {shift_r[6:0], data_s[0]};
        bit_cnt_r <= take ? 4'h0 : bit_cnt_r + 4'h1;
      end
      if (take && periph_mode) begin
        busy_cnt_r <= cps_pkg::BUSY_TICKS;
      end else if (tick && busy_cnt_r != '0) begin
        busy_cnt_r <= busy_cnt_r - 4'h1;
      end
      if (take) begin
        byte_cnt_r <= byte_cnt_r + cps_pkg::CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      config_byte       <= '0;
      config_byte_valid <= 1'b0;
    end else begin
      config_byte_valid <= take;
      if (take) begin
        config_byte <= in_byte;
      end
    end
  end

  // strobe rises on the byte, address steps on the next falling clock
  always_ff @(posedge clk) begin
    if (reset || state_r == cps_pkg::ST_PROG) begin
      addr_r    <= '0;
      astrobe_r <= 1'b0;
    end else if (mode_r == cps_pkg::MODE_MPAR) begin
      if (take) begin
        astrobe_r <= 1'b1;
      end else if (int_fall && astrobe_r) begin
        astrobe_r <= 1'b0;
        addr_r    <= addr_r + cps_pkg::ADDR_W'(1);
      end
    end
  end

  // ==========================================================
  // pin drivers
  always_ff @(posedge clk) begin
    if (reset) begin
      init_out <= 1'b0;
      init_oe  <= 1'b1;
    end else begin
      init_out <= 1'b0;
      init_oe  <= (state_r == cps_pkg::ST_PROG) ||
                  (state_r == cps_pkg::ST_CLEAR) ||
                  (state_r == cps_pkg::ST_ERR);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      done_out       <= 1'b0;
      done_oe        <= 1'b1;
      done_pullup_en <= 1'b1;
    end else begin
      done_out       <= 1'b0;
      done_oe        <= !done_rel_r;
      done_pullup_en <= !ctrl_r[cps_pkg::CTL_DONE_PU_OFF];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      config_clock_out   <= 1'b0;
      config_clock_oe    <= 1'b0;
      readback_clock_sel <= 1'b0;
    end else begin
      config_clock_out   <= config_clock_int_r;
      config_clock_oe    <= clk_run && dev_clocks;
      readback_clock_sel <= config_done &&
                            ctrl_r[cps_pkg::CTL_RB_CLK];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      byte_ready_out    <= 1'b0;
      byte_ready_oe     <= 1'b0;
      byte_ready_pullup <= 1'b1;
      data_out          <= '0;
      data_oe           <= 1'b0;
    end else begin
      byte_ready_out    <= (busy_cnt_r == '0);
      byte_ready_oe     <= init_s && periph_mode &&
                           !config_done;
      byte_ready_pullup <= !init_s;
      data_out          <= {busy_cnt_r == '0, cps_pkg::STAT_FILL};
      data_oe           <= (mode_r == cps_pkg::MODE_PASY) &&
                           (state_r == cps_pkg::ST_LOAD) && selected &&
                           !rstrb_n_s && wstrb_n_s;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prom_address_out   <= '0;
      prom_address_oe    <= 1'b0;
      address_strobe_out <= 1'b0;
      mode_pullup_en     <= 1'b1;
      user_io_enable     <= 1'b0;
      tdo_out            <= 1'b0;
      tdo_oe             <= 1'b1;
    end else begin
      prom_address_out   <= addr_r;
      prom_address_oe    <= (mode_r == cps_pkg::MODE_MPAR) &&
                            (state_r == cps_pkg::ST_LOAD);
      address_strobe_out <= astrobe_r;
      mode_pullup_en     <= !config_done;
      user_io_enable     <= config_done;
      tdo_out            <= scan_data_in;
      tdo_oe             <= ctrl_r[cps_pkg::CTL_BSCAN] ||
                            !config_done;
    end
  end

  // ==========================================================
  // avalon slave: one wait state on every access
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
      ctrl_r          <= cps_pkg::CTRL_RESET;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= '0;
      if (avs_read) begin
        case (avs_address)
          cps_pkg::REG_CTRL:  avs_readdata <= ctrl_r;
          cps_pkg::REG_STAT:  avs_readdata <= {22'h00_0000,
                                               busy_cnt_r == '0,
                                               state_r == cps_pkg::ST_ERR,
                                               config_done, mode_r,
                                               state_r};
          cps_pkg::REG_COUNT: avs_readdata <= 32'(byte_cnt_r);
          default:            avs_readdata <= '0;
        endcase
      end
    end else begin
      avs_waitrequest <= 1'b1;
      if (avs_write && !avs_waitrequest &&
          avs_address == cps_pkg::REG_CTRL) begin
        ctrl_r <= avs_writedata;
      end
    end
  end
endmodule
`default_nettype wire

// ===== cps_top_checker.sv
/* pin assertions of cps_top.
   bound to every cps_top; one clk domain, sync reset. */
`default_nettype none
module cps_top_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        program_n,
  input wire logic        init_oe,
  input wire logic        done_oe,
  input wire logic        mode_pullup_en,
  input wire logic        config_clock_oe,
  input wire logic        readback_clock_sel,
  input wire logic        byte_ready_oe,
  input wire logic        byte_ready_pullup,
  input wire logic [17:0] prom_address_out,
  input wire logic        prom_address_oe,
  input wire logic        address_strobe_out,
  input wire logic        user_io_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ====================================================
  // pin relations
  sequence prog_low_s;
    !program_n [*3];
  endsequence
  sequence clear_run_s;
    init_oe [*8];
  endsequence
  prog_clear_a: assert property (prog_low_s |-> ##[0:3] init_oe)
    else $error("init not pulled on program");
  clear_full_a: assert property ($rose(program_n) |=> clear_run_s)
    else $error("clear cut short");
  addr_strobe_a: assert property (
    prom_address_oe && $past(prom_address_oe) && $changed(prom_address_out)
    |-> $past(address_strobe_out) || $past(address_strobe_out, 2))
    else $error("address moved without strobe");
  user_pins_a: assert property (
    user_io_enable && $past(user_io_enable)
    |-> !mode_pullup_en && !prom_address_oe && !config_clock_oe)
    else $error("config pins active in user state");
  done_user_a: assert property (
    user_io_enable && $past(user_io_enable) |-> !done_oe)
    else $error("done held low in user state");
  ready_weak_a: assert property (byte_ready_pullup |-> !byte_ready_oe)
    else $error("ready driven before init high");
  mode_pull_a: assert property (
    $fell(mode_pullup_en) |-> ##[0:1] user_io_enable)
    else $error("mode pull-ups dropped early");
  rb_clock_a: assert property (
    readback_clock_sel && $past(readback_clock_sel) |-> user_io_enable)
    else $error("readback clock before done");
  master_clk_a: assert property (prom_address_oe |-> config_clock_oe)
    else $error("master parallel without clock drive");
endmodule
bind cps_top cps_top_checker chk_u (.clk, .reset, .program_n, .init_oe,
  .done_oe, .mode_pullup_en, .config_clock_oe, .readback_clock_sel,
  .byte_ready_oe, .byte_ready_pullup, .prom_address_out, .prom_address_oe,
  .address_strobe_out, .user_io_enable);
`default_nettype wire

// ===== cps_top_tb.sv
/* testbench of cps_top: bus tasks, slave serial and master parallel runs.
   assumes cps_src_model as the configuration source. */
`default_nettype none
module cps_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic program_n = 1'b1, data_error = 1'b0, ser_en = 1'b0;
  logic init_oe, done_oe, config_clock_oe, readback_clock_sel, tdo_oe;
  logic avs_waitrequest, mode_pullup_en, prom_address_oe, config_clock_in;
  logic user_io_enable, config_byte_valid, tdo_out, done_pullup_en;
  logic periph_select_high = 1'b0, scan_data_in = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
  logic [2:0]  config_mode_select = 3'h7;
  logic [17:0] prom_address_out;
  logic [7:0]  data_in, config_byte;
  int          num_errors, tests_run, nbytes, cyc, t_init, n;
  // ====================================================
  // design, source and clock
  cps_top #(.CLEAR_CYC(8), .WAIT_CYC(20)) dut_u (
    .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .program_n, .init_in(!init_oe),
    .init_out(), .init_oe, .done_in(!done_oe), .done_out(), .done_oe,
    .done_pullup_en, .config_mode_select, .mode_pullup_en,
    .config_clock_in, .config_clock_out(), .config_clock_oe,
    .readback_clock_sel, .data_in, .data_out(), .data_oe(),
    .periph_select_low(1'b1), .periph_select_high,
    .write_strobe_n(1'b1), .read_strobe_n(1'b1), .byte_ready_out(),
    .byte_ready_oe(), .byte_ready_pullup(), .prom_address_out,
    .prom_address_oe, .address_strobe_out(), .data_error,
    .scan_data_in, .tdo_out, .tdo_oe, .user_io_enable,
    .config_byte, .config_byte_valid);
  cps_src_model src_u (.ser_en, .addr(prom_address_out),
    .addr_oe(prom_address_oe), .link_clk(config_clock_in), .data(data_in));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) begin
    if (config_byte_valid === 1'b1) begin
      chk(config_byte, nbytes[7:0] ^ (config_mode_select[1] ? 8'h3c : 8'ha5));
      nbytes <= nbytes + 1;
    end
  end
  task automatic give_verdict();
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    num_errors++;
    $display("[FAIL] %0t wait timed out", $time);
    give_verdict();
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int k;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k == 50) hang();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic run_prog(input logic [2:0] m);
    config_mode_select <= m;
    program_n <= 1'b0;
    nbytes = 0;
    repeat (6) @(posedge clk);
    chk(init_oe, 1'b1);
    program_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk(init_oe, 1'b1);
    for (n = 0; n < 100 && init_oe !== 1'b0; n++) @(posedge clk);
    if (n == 100) hang();
    t_init = cyc;
  endtask
  // ====================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(1'b0, cps_pkg::REG_CTRL, 32'h0000_0000);
    chk(rd, cps_pkg::CTRL_RESET);
    bus(1'b0, 4'hc, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(1'b1, cps_pkg::REG_CTRL, 32'h0000_030a);
    bus(1'b0, cps_pkg::REG_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_030a);
    chk(done_pullup_en, 1'b0);
    run_prog(3'h7);
    for (n = 0; n < 50 && rd[3:0] !== cps_pkg::ST_LOAD; n++)
      bus(1'b0, cps_pkg::REG_STAT, 32'h0000_0000);
    if (n == 50) hang();
    ser_en <= 1'b1;
    chk(config_clock_oe, 1'b0);
    for (n = 0; n < 3000 && nbytes < 4; n++) @(posedge clk);
    if (n == 3000) hang();
    data_error <= 1'b1;
    @(posedge clk);
    data_error <= 1'b0;
    ser_en <= 1'b0;
    repeat (4) @(posedge clk);
    chk(init_oe, 1'b1);
    run_prog(3'h1);
    for (n = 0; n < 500 && prom_address_oe !== 1'b1; n++) @(posedge clk);
    if (n == 500) hang();
    chk(cyc - t_init >= 20, 1'b1);
    chk(config_clock_oe, 1'b1);
    for (n = 0; n < 3000 && user_io_enable !== 1'b1; n++) @(posedge clk);
    if (n == 3000) hang();
    @(posedge clk);
    chk(done_oe, 1'b0);
    chk(readback_clock_sel, 1'b1);
    chk(mode_pullup_en, 1'b0);
    chk(tdo_oe, 1'b0);
    chk(tdo_out, 1'b1);
    chk(nbytes, 16);
    bus(1'b0, cps_pkg::REG_STAT, 32'h0000_0000);
    chk(rd[6:4], cps_pkg::MODE_MPAR);
    give_verdict();
  end
endmodule
`default_nettype wire
